// File: common/pcsr_cfg.svh
// offsets, field positions, reset values and codes of the coding-sublayer register group
`ifndef PCSR_CFG_SVH
`define PCSR_CFG_SVH

// ----------------------------------------------------------------------
// register indices as printed, byte address is four times the index
// ----------------------------------------------------------------------
`define PCSR_IDX_MAS      16'h18f7
`define PCSR_IDX_LTS      16'h18f8
`define PCSR_IDX_CSC      16'h3000
`define PCSR_IDX_CSA      16'h38e6
`define PCSR_IDX_IRQS     16'h4000
`define PCSR_IDX_IRQM     16'h4001

// ----------------------------------------------------------------------
// sublayer prefix in index bits 15:12
// ----------------------------------------------------------------------
`define PCSR_PFX_PMA      4'h1
`define PCSR_PFX_PCS      4'h3
`define PCSR_PFX_IRQ      4'h4

// ----------------------------------------------------------------------
// reset values and field positions
// ----------------------------------------------------------------------
`define PCSR_MAS_RST      16'h3000
`define PCSR_BIT_POL      2
`define PCSR_BIT_FAULT    1
`define PCSR_BIT_LINK     0
`define PCSR_BIT_SRST     15
`define PCSR_BIT_WRAP     14
`define PCSR_BIT_TRSV     15
`define PCSR_TSEL_HI      15
`define PCSR_TSEL_LO      13
`define PCSR_TSEL_RST     3'h0
`define PCSR_IRQ_RST      3'h0

// ----------------------------------------------------------------------
// interrupt status bits
// ----------------------------------------------------------------------
`define PCSR_IRQ_FAULT    0
`define PCSR_IRQ_LDOWN    1
`define PCSR_IRQ_POLCH    2

// ----------------------------------------------------------------------
// bus codes
// ----------------------------------------------------------------------
`define PCSR_HRESP_OKAY   1'b0

`endif

// File: common/pcsr_pkg.sv
// types shared by the coding-sublayer register group
`default_nettype none
package pcsr_pkg;

    // ------------------------------------------------------------------
    // bus carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        hsel;
        logic [31:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic [31:0] hwdata;
    } pcsr_ahb_req_t;

    typedef struct packed {
        logic        hreadyout;
        logic        hresp;
        logic [31:0] hrdata;
    } pcsr_ahb_rsp_t;

    // ------------------------------------------------------------------
    // line status from the transceiver core
    // ------------------------------------------------------------------
    typedef struct packed {
        logic rxPolarityInv;
        logic rxFault;
        logic rxLinkUp;
    } pcsr_phy_t;

    // ------------------------------------------------------------------
    // bus phase states and test selector codes
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_WR   = 4'b0010,
        ST_RDW  = 4'b0100,
        ST_RDD  = 4'b1000
    } pcsr_state_t;

    typedef enum logic [2:0] {
        TM_NORMAL = 3'h0,
        TM_PAT1   = 3'h1,
        TM_PAT2   = 3'h2,
        TM_PAT3   = 3'h3
    } pcsr_test_t;

endpackage
`default_nettype wire

// File: logic/pcsr_regs.sv
// medium-attachment status and coding-sublayer control registers on ahb-lite
`timescale 1ns/1ns
`default_nettype none
`include "pcsr_cfg.svh"

module pcsr_regs (
    input  wire logic                   clk_sys,
    input  wire logic                   rst,
    input  wire pcsr_pkg::pcsr_ahb_req_t ahbReq,
    output var  pcsr_pkg::pcsr_ahb_rsp_t ahbRsp,
    input  wire pcsr_pkg::pcsr_phy_t     phyIn,
    output logic                        softReset,
    output logic                        wrapEnable,
    output logic [2:0]                  testMode,
    output logic                        irq
);
    import pcsr_pkg::*;

    // ------------------------------------------------------------------
    // address helpers
    // ------------------------------------------------------------------
    function automatic logic [11:0] stripPfx(input logic [15:0] idx);
        stripPfx = idx[11:0];
    endfunction

    function automatic logic isReg(input logic [15:0] idx,
                                   input logic [15:0] printed);
        isReg = (idx[15:12] == printed[15:12]) &&
                (stripPfx(idx) == stripPfx(printed));
    endfunction

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    pcsr_state_t state_r;
    pcsr_state_t state_nxt;
    logic [15:0] idx_r;
    logic        inRange_r;
    logic [15:0] hrdata_r;
    logic        faultLat_r;
    logic        faultLat_nxt;
    logic        linkLat_r;
    logic        linkLat_nxt;
    logic [2:0]  testSel_r;
    logic        softRst_r;
    logic        wrap_r;
    logic        polPrev_r;
    logic        linkPrev_r;
    logic [2:0]  irqStat_r;
    logic [2:0]  irqStat_nxt;
    logic [2:0]  irqMask_r;

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    wire        hready   = (state_r != ST_RDW);
    wire        addrTake = ahbReq.hsel & ahbReq.htrans[1] & hready;
    wire        addrOk   = (ahbReq.haddr[31:18] == 14'h0000);
    wire        wrPhase  = (state_r == ST_WR) & inRange_r;
    wire [15:0] wd       = ahbReq.hwdata[15:0];

    wire hitMas  = inRange_r & isReg(idx_r, `PCSR_IDX_MAS);
    wire hitLts  = inRange_r & isReg(idx_r, `PCSR_IDX_LTS);
    wire hitCsc  = inRange_r & isReg(idx_r, `PCSR_IDX_CSC);
    wire hitCsa  = inRange_r & isReg(idx_r, `PCSR_IDX_CSA);
    wire hitIrqs = inRange_r & isReg(idx_r, `PCSR_IDX_IRQS);
    wire hitIrqm = inRange_r & isReg(idx_r, `PCSR_IDX_IRQM);

    wire wrMas  = wrPhase & hitMas;
    wire wrLts  = wrPhase & hitLts;
    wire wrCtl  = wrPhase & (hitCsc | hitCsa);
    wire wrIrqs = wrPhase & hitIrqs;
    wire wrIrqm = wrPhase & hitIrqm;

    // ------------------------------------------------------------------
    // read words
    // ------------------------------------------------------------------
    wire [15:0] stateWord = `PCSR_MAS_RST |
                            {13'h0000, phyIn.rxPolarityInv,
                             faultLat_r, linkLat_r};
    wire [15:0] testWord  = {testSel_r, 13'h0000};
    wire [15:0] ctlWord   = {softRst_r, wrap_r, 14'h0000};
    wire [15:0] irqsWord  = {13'h0000, irqStat_r};
    wire [15:0] irqmWord  = {13'h0000, irqMask_r};

    wire [15:0] rdMux = hitMas            ? stateWord :
                        hitLts            ? testWord  :
                        (hitCsc | hitCsa) ? ctlWord   :
                        hitIrqs           ? irqsWord  :
                        hitIrqm           ? irqmWord  :
                                            16'h0000;

    // ------------------------------------------------------------------
    // bus phase machine
    // ------------------------------------------------------------------
    always_comb begin
        state_nxt = ST_IDLE;
        case (state_r)
            ST_RDW: state_nxt = ST_RDD;
            default: begin
                if (addrTake) begin
                    state_nxt = ahbReq.hwrite ? ST_WR : ST_RDW;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_r   <= ST_IDLE;
            idx_r     <= 16'h0000;
            inRange_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            if (addrTake) begin
                idx_r     <= ahbReq.haddr[17:2];
                inRange_r <= addrOk;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            hrdata_r <= 16'h0000;
        end else if (state_r == ST_RDW) begin
            hrdata_r <= rdMux;
        end
    end

    assign ahbRsp = {hready, `PCSR_HRESP_OKAY, 16'h0000, hrdata_r};

    // ------------------------------------------------------------------
    // latched line indications
    // ------------------------------------------------------------------
    assign faultLat_nxt = phyIn.rxFault |
        (faultLat_r & ~(wrMas & ~wd[`PCSR_BIT_FAULT]));
    assign linkLat_nxt = (wrMas & ~wd[`PCSR_BIT_LINK]) ?
        phyIn.rxLinkUp : (linkLat_r & phyIn.rxLinkUp);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            faultLat_r <= 1'b0;
            linkLat_r  <= 1'b0;
        end else begin
            faultLat_r <= faultLat_nxt;
            linkLat_r  <= linkLat_nxt;
        end
    end

    // ------------------------------------------------------------------
    // test selector and control word
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            testSel_r <= `PCSR_TSEL_RST;
        end else if (wrLts & ~wd[`PCSR_BIT_TRSV]) begin
            testSel_r <= wd[`PCSR_TSEL_HI:`PCSR_TSEL_LO];
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            softRst_r <= 1'b0;
            wrap_r    <= 1'b0;
        end else begin
            softRst_r <= wrCtl & wd[`PCSR_BIT_SRST];
            if (wrCtl) begin
                wrap_r <= wd[`PCSR_BIT_WRAP];
            end
        end
    end

    assign softReset  = softRst_r;
    assign wrapEnable = wrap_r;
    assign testMode   = testSel_r;

    // ------------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------------
    wire [2:0] evt = {polPrev_r ^ phyIn.rxPolarityInv,
                      linkPrev_r & ~phyIn.rxLinkUp,
                      phyIn.rxFault};
    wire [2:0] irqClr = wrIrqs ? wd[2:0] : 3'h0;

    assign irqStat_nxt = evt | (irqStat_r & ~irqClr);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            polPrev_r  <= 1'b0;
            linkPrev_r <= 1'b0;
            irqStat_r  <= `PCSR_IRQ_RST;
            irqMask_r  <= `PCSR_IRQ_RST;
        end else begin
            polPrev_r  <= phyIn.rxPolarityInv;
            linkPrev_r <= phyIn.rxLinkUp;
            irqStat_r  <= irqStat_nxt;
            if (wrIrqm) begin
                irqMask_r <= wd[2:0];
            end
        end
    end

    assign irq = |(irqStat_r & irqMask_r);

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    wire rdMas = (state_r == ST_RDD) & hitMas;
    wire rdCtl = (state_r == ST_RDD) & (hitCsc | hitCsa);

    property p_mas_reset;
        @(posedge clk_sys) disable iff (rst)
        rdMas |-> ahbRsp.hrdata[15:12] == 4'h3;
    endproperty
    a_mas_reset: assert property (p_mas_reset)
        else $error("state word top nibble wrong");

    property p_loop_abil;
        @(posedge clk_sys) disable iff (rst)
        rdMas |-> ahbRsp.hrdata[13];
    endproperty
    a_loop_abil: assert property (p_loop_abil)
        else $error("loopback ability not reported");

    property p_no_abil;
        @(posedge clk_sys) disable iff (rst)
        rdMas |-> ahbRsp.hrdata[11:9] == 3'h0;
    endproperty
    a_no_abil: assert property (p_no_abil)
        else $error("absent ability reported");

    property p_polarity;
        @(posedge clk_sys) disable iff (rst)
        rdMas |-> ahbRsp.hrdata[2] == $past(phyIn.rxPolarityInv);
    endproperty
    a_polarity: assert property (p_polarity)
        else $error("polarity bit mismatch");

    property p_fault_hold;
        @(posedge clk_sys) disable iff (rst)
        phyIn.rxFault ##1 !(wrMas && !wd[1]) [*3] |=> faultLat_r;
    endproperty
    a_fault_hold: assert property (p_fault_hold)
        else $error("fault latch lost");

    property p_link_low;
        @(posedge clk_sys) disable iff (rst)
        !phyIn.rxLinkUp && !wrMas |=> !linkLat_r;
    endproperty
    a_link_low: assert property (p_link_low)
        else $error("link latch not low");

    property p_test_rsv;
        @(posedge clk_sys) disable iff (rst)
        wrLts && wd[15] |=> testMode == $past(testMode);
    endproperty
    a_test_rsv: assert property (p_test_rsv)
        else $error("reserved test code taken");

    property p_srst_pulse;
        @(posedge clk_sys) disable iff (rst)
        wrCtl && wd[15] ##1 !(wrCtl && wd[15]) |-> softReset ##1 !softReset;
    endproperty
    a_srst_pulse: assert property (p_srst_pulse)
        else $error("soft reset not one cycle");

    property p_wrap_wr;
        @(posedge clk_sys) disable iff (rst)
        wrPhase && hitCsc |=> wrapEnable == $past(wd[14]);
    endproperty
    a_wrap_wr: assert property (p_wrap_wr)
        else $error("loopback enable not written");

    property p_alias_wr;
        @(posedge clk_sys) disable iff (rst)
        wrPhase && hitCsa |=> wrapEnable == $past(wd[14]);
    endproperty
    a_alias_wr: assert property (p_alias_wr)
        else $error("alias write lost");

    property p_rsv_zero;
        @(posedge clk_sys) disable iff (rst)
        rdCtl |-> ahbRsp.hrdata[13:0] == 14'h0000;
    endproperty
    a_rsv_zero: assert property (p_rsv_zero)
        else $error("reserved bits not zero");

    property p_unmapped;
        @(posedge clk_sys) disable iff (rst)
        (state_r == ST_RDD) && !(hitMas || hitLts || hitCsc || hitCsa
            || hitIrqs || hitIrqm) |-> ahbRsp.hrdata == 32'h00000000;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");

    property p_fault_set;
        @(posedge clk_sys) disable iff (rst)
        phyIn.rxFault |=> faultLat_r;
    endproperty
    a_fault_set: assert property (p_fault_set)
        else $error("fault not latched");

    property p_mas_rsv;
        @(posedge clk_sys) disable iff (rst)
        rdMas |-> ahbRsp.hrdata[15:14] == 2'h0 && ahbRsp.hrdata[8:3] == 6'h00;
    endproperty
    a_mas_rsv: assert property (p_mas_rsv)
        else $error("state word reserved bits set");

    property p_lts_rsv;
        @(posedge clk_sys) disable iff (rst)
        (state_r == ST_RDD) && hitLts |-> ahbRsp.hrdata[12:0] == 13'h0000;
    endproperty
    a_lts_rsv: assert property (p_lts_rsv)
        else $error("selector reserved bits set");

    c_alias_wr: cover property (@(posedge clk_sys) disable iff (rst)
        wrPhase && hitCsa);
    c_fault_read: cover property (@(posedge clk_sys) disable iff (rst)
        rdMas && ahbRsp.hrdata[1]);
    c_srst: cover property (@(posedge clk_sys) disable iff (rst)
        softReset);
    c_irq: cover property (@(posedge clk_sys) disable iff (rst)
        irq);
    c_test3: cover property (@(posedge clk_sys) disable iff (rst)
        testMode == TM_PAT3);

endmodule
`default_nettype wire

// File: sim/pcsr_regs_tb.sv
// self-checking bench for the medium-attachment and coding-sublayer registers
`timescale 1ns/1ns
`default_nettype none
`include "pcsr_cfg.svh"

module testbench;
    import pcsr_pkg::*;

    // ------------------------------------------------------------------
    // clock, reset, design
    // ------------------------------------------------------------------
    logic          clk_sys   = 1'b0;
    logic          rst       = 1'b1;
    pcsr_ahb_req_t ahbReq    = '0;
    pcsr_ahb_rsp_t ahbRsp;
    pcsr_phy_t     phyIn     = '0;
    logic          softReset;
    logic          wrapEnable;
    logic [2:0]    testMode;
    logic          irq;
    int            n_errors  = 0;
    int            tests_run = 0;
    int            cycles    = 0;

    always #20 clk_sys = ~clk_sys;

    pcsr_regs pcsr_regs_i (
        .clk_sys    (clk_sys),
        .rst        (rst),
        .ahbReq     (ahbReq),
        .ahbRsp     (ahbRsp),
        .phyIn      (phyIn),
        .softReset  (softReset),
        .wrapEnable (wrapEnable),
        .testMode   (testMode),
        .irq        (irq)
    );

    // ------------------------------------------------------------------
    // report and timeout
    // ------------------------------------------------------------------
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cycles = cycles + 1;
        if (cycles == 3000) begin
            n_errors = n_errors + 1;
            $display("[ERR] t=%0t timeout got=%h exp=%h", $time, cycles, 3000);
            close_out();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // ------------------------------------------------------------------
    // ahb-lite master
    // ------------------------------------------------------------------
    task automatic wait_ready(output logic [31:0] d);
        logic rdy;
        rdy = 1'b0;
        while (rdy !== 1'b1) begin
            @(negedge clk_sys);
            rdy = ahbRsp.hreadyout;
            d = ahbRsp.hrdata;
            @(posedge clk_sys);
        end
    endtask

    task automatic xfer(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
                        output logic [31:0] rd);
        logic [31:0] dummy;
        @(posedge clk_sys);
        ahbReq.hsel <= 1'b1;
        ahbReq.haddr <= {14'h0, idx, 2'b00};
        ahbReq.htrans <= 2'b10;
        ahbReq.hwrite <= wr;
        ahbReq.hsize <= 3'h2;
        wait_ready(dummy);
        ahbReq.hsel <= 1'b0;
        ahbReq.htrans <= 2'b00;
        ahbReq.hwdata <= wd;
        wait_ready(rd);
    endtask

    task automatic wr(input logic [15:0] idx, input logic [15:0] d);
        logic [31:0] dummy;
        xfer(1'b1, idx, {16'h0, d}, dummy);
    endtask

    task automatic rd_chk(input logic [15:0] idx, input logic [15:0] exp);
        logic [31:0] d;
        xfer(1'b0, idx, 32'h0, d);
        check(d, {16'h0, exp});
        check({31'h0, ahbRsp.hresp}, {31'h0, `PCSR_HRESP_OKAY});
    endtask

    task automatic pulse_fault();
        @(posedge clk_sys);
        phyIn.rxFault <= 1'b1;
        @(posedge clk_sys);
        phyIn.rxFault <= 1'b0;
    endtask

    task automatic out_chk(input logic [31:0] exp);
        @(negedge clk_sys);
        check({26'h0, softReset, wrapEnable, testMode, irq}, exp);
        @(posedge clk_sys);
    endtask

    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        rd_chk(`PCSR_IDX_MAS, 16'h3000);
        rd_chk(`PCSR_IDX_LTS, 16'h0000);
        rd_chk(`PCSR_IDX_CSC, 16'h0000);
        rd_chk(`PCSR_IDX_CSA, 16'h0000);
        rd_chk(`PCSR_IDX_IRQM, 16'h0000);
        out_chk(32'h0);
        $display("test reset values done");

        phyIn.rxPolarityInv <= 1'b1;
        rd_chk(`PCSR_IDX_MAS, 16'h3004);
        pulse_fault();
        rd_chk(`PCSR_IDX_MAS, 16'h3006);
        wr(`PCSR_IDX_MAS, 16'h0002);
        rd_chk(`PCSR_IDX_MAS, 16'h3006);
        wr(`PCSR_IDX_MAS, 16'h0000);
        phyIn.rxPolarityInv <= 1'b0;
        rd_chk(`PCSR_IDX_MAS, 16'h3000);
        $display("test polarity and fault done");

        phyIn.rxLinkUp <= 1'b1;
        rd_chk(`PCSR_IDX_MAS, 16'h3000);
        wr(`PCSR_IDX_MAS, 16'h0000);
        rd_chk(`PCSR_IDX_MAS, 16'h3001);
        wr(`PCSR_IDX_MAS, 16'hffff);
        rd_chk(`PCSR_IDX_MAS, 16'h3001);
        phyIn.rxLinkUp <= 1'b0;
        @(posedge clk_sys);
        phyIn.rxLinkUp <= 1'b1;
        rd_chk(`PCSR_IDX_MAS, 16'h3000);
        $display("test link latch done");

        rd_chk(`PCSR_IDX_IRQS, 16'h0007);
        out_chk(32'h0);
        wr(`PCSR_IDX_IRQM, 16'h0002);
        out_chk(32'h1);
        wr(`PCSR_IDX_IRQS, 16'h0005);
        rd_chk(`PCSR_IDX_IRQS, 16'h0002);
        wr(`PCSR_IDX_IRQS, 16'h0002);
        out_chk(32'h0);
        wr(`PCSR_IDX_IRQM, 16'h0007);
        pulse_fault();
        out_chk(32'h1);
        wr(`PCSR_IDX_IRQS, 16'h0001);
        out_chk(32'h0);
        rd_chk(`PCSR_IDX_IRQS, 16'h0000);
        $display("test interrupts done");

        for (int c = 0; c < 4; c++) begin
            wr(`PCSR_IDX_LTS, {c[2:0], 13'h1fff});
            rd_chk(`PCSR_IDX_LTS, {c[2:0], 13'h0});
            out_chk({28'h0, c[2:0], 1'b0});
        end
        wr(`PCSR_IDX_LTS, 16'h8000);
        rd_chk(`PCSR_IDX_LTS, 16'h6000);
        out_chk(32'h6);
        $display("test selector done");

        wr(`PCSR_IDX_CSC, 16'h4000);
        out_chk(32'h16);
        rd_chk(`PCSR_IDX_CSA, 16'h4000);
        wr(`PCSR_IDX_CSA, 16'hc000);
        out_chk(32'h36);
        out_chk(32'h16);
        rd_chk(`PCSR_IDX_CSC, 16'h4000);
        wr(`PCSR_IDX_CSC, 16'h3fff);
        rd_chk(`PCSR_IDX_CSA, 16'h0000);
        out_chk(32'h6);
        $display("test control word done");

        rd_chk(16'h08f7, 16'h0000);
        rd_chk(16'h38f7, 16'h0000);
        wr(16'h08f8, 16'h2000);
        rd_chk(`PCSR_IDX_LTS, 16'h6000);
        rd_chk(16'h1000, 16'h0000);
        wr(16'h1000, 16'h4000);
        rd_chk(`PCSR_IDX_CSC, 16'h0000);
        rd_chk(16'h0003, 16'h0000);
        $display("test prefixes done");
        close_out();
    end
endmodule
`default_nettype wire
